// [design/tpu_pkg.sv]
// Package: constants for the five-instance timer/counter/PWM unit
package tpu_pkg;
  localparam int unsigned NUM_UNITS   = 5;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned DT_W        = 8;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] PERIOD_RST  = 16'hffff;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [7:0]  DT_RST      = 8'h00;
  localparam logic        KILL_TRUE   = 1'b0;
  localparam logic        KILL_COMP   = 1'b0;
  localparam real         CLK_MHZ     = 25.0;
  localparam real         CLK_NS      = 1000.0 / CLK_MHZ;
endpackage : tpu_pkg

// [design/tpu_timer_pwm_unit.sv]
// Module: five independent 16-bit timer/counter/PWM units with dead band and kill
`timescale 1ns/1ps
module tpu_timer_pwm_unit (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic [4:0]  enable_i,
  input  wire logic [4:0]  tick_i,
  input  wire logic [4:0]  reload_mode_i,
  input  wire logic [4:0]  start_i,
  input  wire logic [79:0] period_i,
  input  wire logic [79:0] compare_i,
  input  wire logic [39:0] dead_band_i,
  input  wire logic [4:0]  capture_pin_i,
  input  wire logic [4:0]  kill_pin_i,
  output logic      [79:0] count_o,
  output logic      [79:0] capture_o,
  output logic      [4:0]  capture_valid_o,
  output logic      [4:0]  running_o,
  output logic      [4:0]  period_match_o,
  output logic      [4:0]  pwm_true_o,
  output logic      [4:0]  pwm_comp_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] cap_s1;
  logic [4:0] cap_s2;
  logic [4:0] cap_s3;
  logic [4:0] kill_s1;
  logic [4:0] kill_s2;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cap_s1  <= 5'h00;
      cap_s2  <= 5'h00;
      cap_s3  <= 5'h00;
      kill_s1 <= 5'h00;
      kill_s2 <= 5'h00;
    end
    else
    begin
      cap_s1  <= capture_pin_i;
      cap_s2  <= cap_s1;
      // Third stage only feeds the edge detector
      cap_s3  <= cap_s2;
      kill_s1 <= kill_pin_i;
      kill_s2 <= kill_s1;
    end
  end

  // ----------------------------------------------------------------
  // Per-unit logic
  // ----------------------------------------------------------------
  // five copies
  genvar g;
  generate
    for (g = 0; g < tpu_pkg::NUM_UNITS; g++)
    begin : g_unit

      // ------------------------------------------------------------
      // Unit state
      // ------------------------------------------------------------
      logic [15:0] cnt;
      logic [15:0] cap;
      logic        cap_vld;
      logic        run;
      logic        pwm_raw;
      logic        raw_d;
      logic        t_out;
      logic        c_out;
      logic [7:0]  dt_cnt;
      logic [15:0] per;
      logic [15:0] cmp;
      logic [7:0]  dt;
      logic        match;
      logic        cap_evt;

      assign per     = period_i[g*16 +: 16];
      assign cmp     = compare_i[g*16 +: 16];
      assign dt      = dead_band_i[g*8 +: 8];
      // Match only while running and on a tick, so a stopped count never fires again
      // match with period
      assign match   = run && tick_i[g] && (cnt == per);
      assign cap_evt = cap_s2[g] && !cap_s3[g];


      // ------------------------------------------------------------
      // Counter
      // ------------------------------------------------------------
      // counter with period
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          cnt <= tpu_pkg::CNT_RST;
          run <= 1'b0;
        end
        else if (!enable_i[g])
        begin
          cnt <= tpu_pkg::CNT_RST;
          run <= 1'b0;
        end
        else if (start_i[g])
        begin
          cnt <= tpu_pkg::CNT_RST;
          run <= 1'b1;
        end
        else if (match)
        begin
          cnt <= tpu_pkg::CNT_RST;
          run <= reload_mode_i[g];
        end
        else if (run && tick_i[g])
        begin
          cnt <= cnt + 16'h0001;
        end
      end


      // ------------------------------------------------------------
      // Capture
      // ------------------------------------------------------------
      // Valid lasts one cycle; a slow reader must latch it
      // capture count
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          cap     <= tpu_pkg::CNT_RST;
          cap_vld <= 1'b0;
        end
        else
        begin
          cap_vld <= cap_evt;
          if (cap_evt)
          begin
            cap <= cnt;
          end
        end
      end


      // ------------------------------------------------------------
      // Dead band
      // ------------------------------------------------------------
      // Dead band delays each rising edge of either output by dt cycles
      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          pwm_raw <= 1'b0;
          raw_d   <= 1'b0;
          dt_cnt  <= tpu_pkg::DT_RST;
          t_out   <= 1'b0;
          c_out   <= 1'b0;
        end
        else
        begin
          pwm_raw <= enable_i[g] && (cnt < cmp);
          raw_d   <= pwm_raw;
          if (pwm_raw != raw_d)
          begin
            t_out  <= 1'b0;
            c_out  <= 1'b0;
            dt_cnt <= dt;
            if (dt == 8'h00)
            begin
              t_out <= pwm_raw;
              c_out <= !pwm_raw;
            end
          end
          else if (dt_cnt != 8'h00)
          begin
            dt_cnt <= dt_cnt - 8'h01;
            if (dt_cnt == 8'h01)
            begin
              t_out <= pwm_raw;
              c_out <= !pwm_raw;
            end
          end
          else
          begin
            t_out <= pwm_raw;
            c_out <= !pwm_raw;
          end
        end
      end


      // ------------------------------------------------------------
      // Outputs
      // ------------------------------------------------------------
      // Kill gates after the flops, so it acts within the sync delay
      // kill forces safe state
      assign pwm_true_o[g]        = kill_s2[g] ? tpu_pkg::KILL_TRUE : t_out;
      assign pwm_comp_o[g]        = kill_s2[g] ? tpu_pkg::KILL_COMP : c_out;
      assign count_o[g*16 +: 16]   = cnt;
      assign capture_o[g*16 +: 16] = cap;
      assign capture_valid_o[g]   = cap_vld;
      assign running_o[g]         = run;
      assign period_match_o[g]    = match;
    end
  endgenerate

endmodule : tpu_timer_pwm_unit

// [sim/tpu_props.sv]
// Checker: counting, capture and kill of unit 0, output pairing of all five units
`timescale 1ns/1ps
module tpu_props (
  input logic        clk_sys_i, rst_b_i,
  input logic [4:0]  enable_i, tick_i, reload_mode_i, start_i, capture_pin_i, kill_pin_i,
  input logic [79:0] period_i, count_o,
  input logic [4:0]  capture_valid_o, running_o, period_match_o, pwm_true_o, pwm_comp_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Start outranks the match, so leave it out
  wire        go  = enable_i[0] & !start_i[0];
  wire [15:0] cnt = count_o[15:0];
  property p_wrap; go & period_match_o[0] & reload_mode_i[0] |=> cnt == 16'h0 & running_o[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no reload at match");
  property p_halt; go & period_match_o[0] & !reload_mode_i[0] |=> !running_o[0]; endproperty
  a_halt: assert property (p_halt) else $error("no halt at match");
  property p_inc; go & running_o[0] & tick_i[0] & !period_match_o[0]
    |=> cnt == $past(cnt) + 16'h1; endproperty
  a_inc: assert property (p_inc) else $error("count did not step");
  property p_start; enable_i[0] & start_i[0] |=> cnt == 16'h0 & running_o[0]; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_match; period_match_o[0] |-> cnt == period_i[15:0] & running_o[0]; endproperty
  a_match: assert property (p_match) else $error("false match");
  property p_cap; $rose(capture_pin_i[0]) |-> ##[2:6] capture_valid_o[0]; endproperty
  a_cap: assert property (p_cap) else $error("capture missed");
  property p_kill; kill_pin_i[0] [*3] |-> !pwm_true_o[0] & !pwm_comp_o[0]; endproperty
  a_kill: assert property (p_kill) else $error("kill not forcing");
  property p_excl; (pwm_true_o & pwm_comp_o) == 5'h0; endproperty
  a_excl: assert property (p_excl) else $error("both outputs high");
endmodule : tpu_props
bind tpu_timer_pwm_unit tpu_props u_props (.*);

// [sim/tpu_bridge.sv]
// Power stage model: one leg, latches any shoot-through
`timescale 1ns/1ps
module tpu_bridge (
  input  wire logic clk_i,
  input  wire logic hi_i,
  input  wire logic lo_i,
  output logic      shoot_o
);
  initial shoot_o = 1'b0;
  always @(posedge clk_i) shoot_o <= shoot_o | (hi_i & lo_i);
endmodule : tpu_bridge

// [sim/tb_top.sv]
// Testbench for the five timer/PWM units
`timescale 1ns/1ps
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value %0t %h %h", $time, a, b); end end
module tb_top;
  logic        clk_sys_i, rst_b_i, shoot;
  logic [4:0]  enable_i, tick_i, reload_mode_i, start_i, capture_pin_i, kill_pin_i;
  logic [79:0] period_i, compare_i, count_o, capture_o;
  logic [39:0] dead_band_i;
  logic [4:0]  capture_valid_o, running_o, period_match_o, pwm_true_o, pwm_comp_o;
  int          n_errors = 0, n_checks = 0;
  tpu_timer_pwm_unit DUT (.*);
  tpu_bridge u_bridge (.clk_i(clk_sys_i), .hi_i(pwm_true_o[0]), .lo_i(pwm_comp_o[0]),
    .shoot_o(shoot));
  initial begin clk_sys_i = 1'b0; forever #20 clk_sys_i = ~clk_sys_i; end
  task automatic cyc(int n); repeat (n) @(posedge clk_sys_i); endtask : cyc
  task automatic go(int u, logic [15:0] per, logic rl);
    period_i[u*16+:16] <= per; reload_mode_i[u] <= rl; start_i[u] <= 1'b1;
    cyc(1); start_i[u] <= 1'b0;
  endtask : go
  task automatic s_reload;
    go(0, 16'h0002, 1'b1); tick_i[0] <= 1'b1;
    for (int i = 1; i <= 7; i++) begin cyc(1); #1 `CHK(count_o[15:0], 16'(i % 3)) end
    cyc(1); #1 `CHK(period_match_o[0], 1'b1)
    cyc(1); #1 `CHK(period_match_o[0], 1'b0)
  endtask : s_reload
  task automatic s_halt;
    go(0, 16'h0002, 1'b0); cyc(4); #1;
    `CHK({running_o[0], count_o[15:0]}, 17'h0)
  endtask : s_halt
  task automatic s_cap(int u);
    tick_i[u] <= 1'b0; go(u, 16'hffff, 1'b1);
    tick_i[u] <= 1'b1; cyc(5); tick_i[u] <= 1'b0; capture_pin_i[u] <= 1'b1;
    for (int i = 0; i < 9 && capture_valid_o[u] !== 1'b1; i++) begin cyc(1); #1; end
    `CHK(capture_o[u*16+:16], 16'h0005)
    `CHK(capture_valid_o[u], 1'b1)
    cyc(1); #1 `CHK(capture_valid_o[u], 1'b0)
    capture_pin_i[u] <= 1'b0;
  endtask : s_cap
  task automatic s_pwm;
    compare_i[15:0] <= 16'hffff; dead_band_i[7:0] <= 8'h03; go(0, 16'hffff, 1'b1);
    cyc(10); #1 `CHK({pwm_true_o[0], pwm_comp_o[0]}, 2'b10)
    kill_pin_i[0] <= 1'b1; cyc(3); #1 `CHK({pwm_true_o[0], pwm_comp_o[0]}, 2'b00)
    kill_pin_i[0] <= 1'b0; compare_i[15:0] <= 16'h0000;
    cyc(3); #1 `CHK({pwm_true_o[0], pwm_comp_o[0]}, 2'b00)
    cyc(7); #1 `CHK({pwm_true_o[0], pwm_comp_o[0]}, 2'b01)
  endtask : s_pwm
  task automatic give_verdict;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    {tick_i, reload_mode_i, start_i, capture_pin_i, kill_pin_i} = '0;
    {period_i, compare_i, dead_band_i} = '0;
    enable_i = 5'h1f; rst_b_i = 1'b0;
    cyc(6); rst_b_i <= 1'b1;
    s_reload; s_halt; s_cap(0); s_cap(4); s_pwm;
    `CHK(shoot, 1'b0)
    give_verdict;
  end
  // Run needs about 65 cycles; allow thirty times that
  initial begin #80000; n_errors++; give_verdict; end
endmodule : tb_top
